// >>> rtl/prc_top.sv
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Writing 1 to bit 31 starts a system reset and the bit reads 1 until it is done.
// - Bit 30 resets all peripherals while this control register keeps its state.
// - Bit 29 launches a soft reset and returns to 0 once it has finished.
// - Bits 28, 12 and 11 reset the three serial ports and clear on completion.
// - Bits 15, 14 and 13 reset the three SPI ports and clear on completion.
// - Bits 20 and 19 reset the CAN ports, bit 16 the I2C port, each self-clearing.
// - Bits 8 to 5 reset the four timers and clear on completion.
// - Bits 4, 3 and 2 reset the three I/O ports and clear on completion.
// - Bit 1 resets the watchdog and clears when that reset is done.
// - Bit 0 resets the DMA block and clears when that reset is done.
// - Bit 26 resets the converter and bit 24 the random generator, each self-clearing.
// - Bits 23, 22 and 21 reset USB, semaphore and external memory bus blocks.
// - Bit 18 resets the crypto block and bit 17 the real-time clock, each self-clearing.
module prc_top
  import prc_pkg::*;
#(
  parameter int ADDR_W  = 12,
  parameter int MIN_CYC = MIN_PULSE_CYC
) (
  input  wire logic              clock,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [31:0]       unit_reset_done,
  output logic                   system_reset,
  output logic                   peripheral_reset,
  output logic                   soft_reset,
  output logic                   serial_port_a_reset,
  output logic                   serial_port_b_reset,
  output logic                   serial_port_c_reset,
  output logic                   spi_port_a_reset,
  output logic                   spi_port_b_reset,
  output logic                   spi_port_c_reset,
  output logic                   i2c_port_a_reset,
  output logic                   can_port_a_reset,
  output logic                   can_port_b_reset,
  output logic                   timer_a_reset,
  output logic                   timer_b_reset,
  output logic                   timer_c_reset,
  output logic                   timer_d_reset,
  output logic                   io_port_a_reset,
  output logic                   io_port_b_reset,
  output logic                   io_port_c_reset,
  output logic                   watchdog_reset,
  output logic                   dma_reset,
  output logic                   converter_reset,
  output logic                   rng_reset,
  output logic                   usb_reset,
  output logic                   semaphore_reset,
  output logic                   ext_mem_bus_reset,
  output logic                   crypto_reset,
  output logic                   rtc_reset
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus.

  logic        wr_en;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic [31:0] strb_bits;
  logic [31:0] start;
  logic [31:0] ctrl;
  logic        wide_rst;

  prc_axil_slave #(
    .ADDR_W (ADDR_W)
  ) u_bus (
    .clock         (clock),
    .rstn          (rstn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .rd_value      (ctrl)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Reset channels, one per implemented bit.

  assign strb_bits = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};

  // Only ones start a reset; zeros in the same word leave busy bits alone.
  assign start = {32{wr_en}} & wr_data & strb_bits & RST_IMPL_MASK;

  for (genvar b = 0; b < 32; b++) begin : g_chan
    if (RST_IMPL_MASK[b]) begin : g_impl
      prc_reset_channel #(
        .MIN_CYC (MIN_CYC)
      ) u_chan (
        .clock (clock),
        .rstn  (rstn),
        .start (start[b]),
        .done  (unit_reset_done[b]),
        .busy  (ctrl[b])
      );
    end else begin : g_rsvd
      assign ctrl[b] = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reset outputs.

  assign system_reset     = ctrl[BIT_SYS];
  assign peripheral_reset = ctrl[BIT_PERIPH];
  assign soft_reset       = ctrl[BIT_SOFT];

  // Whole-system and peripheral resets reach every unit; this register is not among them.
  assign wide_rst = ctrl[BIT_SYS] | ctrl[BIT_PERIPH];

  assign serial_port_a_reset = ctrl[BIT_SER_A] | wide_rst;
  assign serial_port_b_reset = ctrl[BIT_SER_B] | wide_rst;
  assign serial_port_c_reset = ctrl[BIT_SER_C] | wide_rst;
  assign spi_port_a_reset    = ctrl[BIT_SPI_A] | wide_rst;
  assign spi_port_b_reset    = ctrl[BIT_SPI_B] | wide_rst;
  assign spi_port_c_reset    = ctrl[BIT_SPI_C] | wide_rst;
  assign i2c_port_a_reset    = ctrl[BIT_I2C_A] | wide_rst;
  assign can_port_a_reset    = ctrl[BIT_CAN_A] | wide_rst;
  assign can_port_b_reset    = ctrl[BIT_CAN_B] | wide_rst;
  assign timer_a_reset       = ctrl[BIT_TMR_A] | wide_rst;
  assign timer_b_reset       = ctrl[BIT_TMR_B] | wide_rst;
  assign timer_c_reset       = ctrl[BIT_TMR_C] | wide_rst;
  assign timer_d_reset       = ctrl[BIT_TMR_D] | wide_rst;
  assign io_port_a_reset     = ctrl[BIT_IO_A] | wide_rst;
  assign io_port_b_reset     = ctrl[BIT_IO_B] | wide_rst;
  assign io_port_c_reset     = ctrl[BIT_IO_C] | wide_rst;
  assign watchdog_reset      = ctrl[BIT_WDOG] | wide_rst;
  assign dma_reset           = ctrl[BIT_DMA] | wide_rst;
  assign converter_reset     = ctrl[BIT_CONV] | wide_rst;
  assign rng_reset           = ctrl[BIT_RNG] | wide_rst;
  assign usb_reset           = ctrl[BIT_USB] | wide_rst;
  assign semaphore_reset     = ctrl[BIT_SEMA] | wide_rst;
  assign ext_mem_bus_reset   = ctrl[BIT_EXTMEM] | wide_rst;
  assign crypto_reset        = ctrl[BIT_CRYPTO] | wide_rst;
  assign rtc_reset           = ctrl[BIT_RTC] | wide_rst;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  // Cycles since the timer D bit was last started, saturating; it bounds the completion check.
  logic [7:0] tmr_d_age_r;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tmr_d_age_r <= 8'h00;
    end else if (start[BIT_TMR_D]) begin
      tmr_d_age_r <= 8'h01;
    end else if (tmr_d_age_r != 8'hFF) begin
      tmr_d_age_r <= tmr_d_age_r + 8'h01;
    end
  end

  sys_start_a : assert property (
    @(posedge clock) disable iff (!rstn)
    start[BIT_SYS] |=> ctrl[BIT_SYS] && system_reset && dma_reset)
    else $error("System reset did not start on write.");

  sys_clear_a : assert property (
    @(posedge clock) disable iff (!rstn)
    $fell(ctrl[BIT_SYS]) |-> $past(unit_reset_done[BIT_SYS]) && !$past(start[BIT_SYS]))
    else $error("System reset bit cleared without completion.");

  periph_all_a : assert property (
    @(posedge clock) disable iff (!rstn)
    start[BIT_PERIPH] |=> peripheral_reset && serial_port_a_reset && rtc_reset
      && timer_d_reset && !soft_reset)
    else $error("Peripheral reset did not reach the units.");

  soft_clear_a : assert property (
    @(posedge clock) disable iff (!rstn)
    $rose(ctrl[BIT_SOFT]) |-> soft_reset ##1 ctrl[BIT_SOFT][*3])
    else $error("Soft reset bit dropped too early.");

  serial_start_a : assert property (
    @(posedge clock) disable iff (!rstn)
    wr_en && wr_strb[3] && wr_data[BIT_SER_C] |=> serial_port_c_reset && ctrl[BIT_SER_C])
    else $error("Serial port reset did not start.");

  spi_pair_a : assert property (
    @(posedge clock) disable iff (!rstn)
    ctrl[BIT_SPI_B] && !wide_rst |-> spi_port_b_reset
      && (spi_port_a_reset == ctrl[BIT_SPI_A]))
    else $error("SPI reset output does not follow its bit.");

  can_done_a : assert property (
    @(posedge clock) disable iff (!rstn)
    $fell(ctrl[BIT_CAN_A]) |-> $past(unit_reset_done[BIT_CAN_A]))
    else $error("CAN reset bit cleared without completion.");

  timer_pulse_a : assert property (
    @(posedge clock) disable iff (!rstn)
    $fell(ctrl[BIT_TMR_A]) |-> $past(ctrl[BIT_TMR_A], MIN_CYC))
    else $error("Timer reset pulse shorter than the minimum.");

  timer_done_a : assert property (
    @(posedge clock) disable iff (!rstn)
    ctrl[BIT_TMR_D] && unit_reset_done[BIT_TMR_D] && !start[BIT_TMR_D]
      && (tmr_d_age_r >= MIN_CYC) |=> !ctrl[BIT_TMR_D])
    else $error("Timer reset bit did not clear after completion.");

  io_zero_a : assert property (
    @(posedge clock) disable iff (!rstn)
    ctrl[BIT_IO_A] && !unit_reset_done[BIT_IO_A] |=> ctrl[BIT_IO_A] && io_port_a_reset)
    else $error("I/O port reset aborted before completion.");

  wdog_start_a : assert property (
    @(posedge clock) disable iff (!rstn)
    start[BIT_WDOG] |=> watchdog_reset ##1 watchdog_reset)
    else $error("Watchdog reset did not start.");

  dma_hold_a : assert property (
    @(posedge clock) disable iff (!rstn)
    ctrl[BIT_DMA] |-> dma_reset)
    else $error("DMA reset output low while its bit is set.");

  conv_rng_a : assert property (
    @(posedge clock) disable iff (!rstn)
    start[BIT_CONV] && start[BIT_RNG] |=> converter_reset && rng_reset)
    else $error("Converter and generator resets did not start together.");

  group_start_a : assert property (
    @(posedge clock) disable iff (!rstn)
    start[BIT_USB] && start[BIT_EXTMEM] && start[BIT_CRYPTO]
      |=> usb_reset && ext_mem_bus_reset && crypto_reset
      && (ctrl[BIT_SEMA] || !$past(start[BIT_SEMA])))
    else $error("Resets written together did not start together.");

  rsvd_zero_a : assert property (
    @(posedge clock) disable iff (!rstn)
    (ctrl & ~RST_IMPL_MASK) == 32'h0000_0000)
    else $error("Reserved control bits read as one.");

  rtc_done_a : assert property (
    @(posedge clock) disable iff (!rstn)
    $fell(rtc_reset) |-> $past(unit_reset_done[BIT_RTC]) || $past(wide_rst))
    else $error("Real-time clock reset ended without completion.");

  ser_done_a : assert property (
    @(posedge clock) disable iff (!rstn)
    $fell(ctrl[BIT_SER_A]) |-> $past(unit_reset_done[BIT_SER_A]))
    else $error("Serial port reset bit cleared without completion.");

  spi_done_a : assert property (
    @(posedge clock) disable iff (!rstn)
    $fell(ctrl[BIT_SPI_C]) |-> $past(unit_reset_done[BIT_SPI_C]))
    else $error("SPI reset bit cleared without completion.");

  io_done_a : assert property (
    @(posedge clock) disable iff (!rstn)
    $fell(ctrl[BIT_IO_C]) |-> $past(unit_reset_done[BIT_IO_C]))
    else $error("I/O port reset bit cleared without completion.");

  zero_write_a : assert property (
    @(posedge clock) disable iff (!rstn)
    wr_en && !wr_data[BIT_USB] && !ctrl[BIT_USB] |=> !ctrl[BIT_USB])
    else $error("Writing zero started a USB reset.");

  lane_gate_a : assert property (
    @(posedge clock) disable iff (!rstn)
    wr_en && !wr_strb[0] && !ctrl[BIT_WDOG] |=> !ctrl[BIT_WDOG])
    else $error("A gated byte lane started a watchdog reset.");

  sema_start_a : assert property (
    @(posedge clock) disable iff (!rstn)
    start[BIT_SEMA] |=> semaphore_reset && ctrl[BIT_SEMA])
    else $error("Semaphore reset did not start on write.");

endmodule

// >>> common/prc_pkg.sv
package prc_pkg;

  // Timing of the minimum reset pulse.
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          MIN_PULSE_NS    = 100;
  localparam int          MIN_PULSE_CYC   = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register map.
  localparam logic [31:0] RST_CTRL_OFFSET = 32'h0000_0004;
  localparam logic [31:0] RST_CTRL_RESET  = 32'h0000_0000;
  localparam logic [31:0] RST_IMPL_MASK   = 32'hF5FF_F9FF;

  // Bus responses.
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_DECERR     = 2'h3;

  // Field positions of the reset control register.
  localparam int          BIT_SYS         = 31;
  localparam int          BIT_PERIPH      = 30;
  localparam int          BIT_SOFT        = 29;
  localparam int          BIT_SER_C       = 28;
  localparam int          BIT_CONV        = 26;
  localparam int          BIT_RNG         = 24;
  localparam int          BIT_USB         = 23;
  localparam int          BIT_SEMA        = 22;
  localparam int          BIT_EXTMEM      = 21;
  localparam int          BIT_CAN_B       = 20;
  localparam int          BIT_CAN_A       = 19;
  localparam int          BIT_CRYPTO      = 18;
  localparam int          BIT_RTC         = 17;
  localparam int          BIT_I2C_A       = 16;
  localparam int          BIT_SPI_C       = 15;
  localparam int          BIT_SPI_B       = 14;
  localparam int          BIT_SPI_A       = 13;
  localparam int          BIT_SER_B       = 12;
  localparam int          BIT_SER_A       = 11;
  localparam int          BIT_TMR_D       = 8;
  localparam int          BIT_TMR_C       = 7;
  localparam int          BIT_TMR_B       = 6;
  localparam int          BIT_TMR_A       = 5;
  localparam int          BIT_IO_C        = 4;
  localparam int          BIT_IO_B        = 3;
  localparam int          BIT_IO_A        = 2;
  localparam int          BIT_WDOG        = 1;
  localparam int          BIT_DMA         = 0;

endpackage

// >>> rtl/prc_reset_channel.sv
`timescale 1ns/100ps
module prc_reset_channel
  import prc_pkg::*;
#(
  parameter int MIN_CYC = MIN_PULSE_CYC
) (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic start,
  input  wire logic done,
  output logic      busy
);

  localparam int CW = $clog2(MIN_CYC + 1);

  logic [CW-1:0] cnt_r;
  logic          busy_r;
  logic          held;

  if (MIN_CYC < 1) begin : g_chk
    $error("MIN_CYC must be at least 1.");
  end

  assign held = (cnt_r == CW'(MIN_CYC - 1));
  assign busy = busy_r;

  // A new start wins over completion and restarts the pulse.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      busy_r <= 1'b0;
    end else if (start) begin
      busy_r <= 1'b1;
    end else if (held && done) begin
      busy_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
    end else if (start || !busy_r) begin
      cnt_r <= '0;
    end else if (!held) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

endmodule

// >>> rtl/prc_axil_slave.sv
`timescale 1ns/100ps
module prc_axil_slave
  import prc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              clock,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   wr_en,
  output logic [31:0]            wr_data,
  output logic [3:0]             wr_strb,
  input  wire logic [31:0]       rd_value
);

  if (ADDR_W < 4 || ADDR_W > 32) begin : g_chk
    $error("ADDR_W must lie between 4 and 32.");
  end

  logic        aw_held_r;
  logic        aw_hit_r;
  logic        w_held_r;
  logic        bvalid_r;
  logic        rvalid_r;
  logic        commit;
  logic        ar_hit;
  logic [1:0]  bresp_r;
  logic [1:0]  rresp_r;
  logic [31:0] wdata_r;
  logic [31:0] rdata_r;
  logic [3:0]  wstrb_r;

  function automatic logic hit(input logic [ADDR_W-1:0] a);
    hit = ({a[ADDR_W-1:2], 2'b00} == RST_CTRL_OFFSET[ADDR_W-1:0]);
  endfunction

  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready  = !w_held_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;
  assign commit        = aw_held_r && w_held_r;
  assign ar_hit        = hit(s_axi_araddr);
  assign wr_en         = commit && aw_hit_r;
  assign wr_data       = wdata_r;
  assign wr_strb       = wstrb_r;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      aw_held_r <= 1'b0;
      aw_hit_r  <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      aw_hit_r  <= hit(s_axi_awaddr);
    end else if (commit) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      w_held_r <= 1'b0;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      wdata_r  <= s_axi_wdata;
      wstrb_r  <= s_axi_wstrb;
    end else if (commit) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (commit) begin
      bvalid_r <= 1'b1;
      bresp_r  <= aw_hit_r ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rdata_r  <= ar_hit ? rd_value : 32'h0000_0000;
      rresp_r  <= ar_hit ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule

// >>> test/prc_unit_model.sv
`timescale 1ns/100ps
module prc_unit_model (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic [31:0] unit_reset,
  input  wire logic [7:0]  ack_delay,
  output logic      [31:0] unit_reset_done
);
  logic [7:0] cnt_r [32];

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int b = 0; b < 32; b++) cnt_r[b] <= 8'h00;
    end else begin
      for (int b = 0; b < 32; b++) begin
        if (!unit_reset[b]) cnt_r[b] <= 8'h00;
        else if (cnt_r[b] != 8'hFF) cnt_r[b] <= cnt_r[b] + 8'h01;
      end
    end
  end

  // A unit reports completion only after holding its reset for ack_delay cycles.
  always_comb begin
    for (int b = 0; b < 32; b++) begin
      unit_reset_done[b] = unit_reset[b] && (cnt_r[b] >= ack_delay);
    end
  end
endmodule

// >>> test/prc_top_bench.sv
`timescale 1ns/100ps
module prc_top_bench;
  import prc_pkg::*;
  localparam int          MC  = 4;
  localparam logic [11:0] OFF = RST_CTRL_OFFSET[11:0];
  localparam logic [31:0] UM  = RST_IMPL_MASK & 32'h1FFF_FFFF;
  logic        clock, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, v;
  logic [3:0]  wstrb;
  logic [7:0]  ack_delay;
  wire         awready, wready, bvalid, arready, rvalid;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata, done_v, rst_v;
  int          errors, n_checks, cyc;

  assign rst_v[27] = 1'b0;
  assign rst_v[25] = 1'b0;
  assign rst_v[10:9] = 2'h0;

  prc_top #(.ADDR_W(12), .MIN_CYC(MC)) dut_u (
    .clock(clock), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .unit_reset_done(done_v), .system_reset(rst_v[31]), .peripheral_reset(rst_v[30]),
    .soft_reset(rst_v[29]), .serial_port_a_reset(rst_v[11]),
    .serial_port_b_reset(rst_v[12]), .serial_port_c_reset(rst_v[28]),
    .spi_port_a_reset(rst_v[13]), .spi_port_b_reset(rst_v[14]),
    .spi_port_c_reset(rst_v[15]), .i2c_port_a_reset(rst_v[16]),
    .can_port_a_reset(rst_v[19]), .can_port_b_reset(rst_v[20]),
    .timer_a_reset(rst_v[5]), .timer_b_reset(rst_v[6]), .timer_c_reset(rst_v[7]),
    .timer_d_reset(rst_v[8]), .io_port_a_reset(rst_v[2]), .io_port_b_reset(rst_v[3]),
    .io_port_c_reset(rst_v[4]), .watchdog_reset(rst_v[1]), .dma_reset(rst_v[0]),
    .converter_reset(rst_v[26]), .rng_reset(rst_v[24]), .usb_reset(rst_v[23]),
    .semaphore_reset(rst_v[22]), .ext_mem_bus_reset(rst_v[21]),
    .crypto_reset(rst_v[18]), .rtc_reset(rst_v[17]));

  prc_unit_model unit_u (.clock(clock), .rstn(rstn), .unit_reset(rst_v),
    .ack_delay(ack_delay), .unit_reset_done(done_v));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Ready and valid are sampled at the falling edge, where they are settled.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge clock);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      r = bresp;
      @(posedge clock);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
    chk({30'h0, r}, {30'h0, er});
  endtask

  task automatic rd(input logic [11:0] a, input logic [1:0] er, output logic [31:0] d);
    logic ta, tr;
    logic [1:0] r;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge clock);
      ta = arvalid && arready;
      tr = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge clock);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end
    chk({30'h0, r}, {30'h0, er});
  endtask

  task automatic wait_clear(input logic [31:0] m);
    logic [31:0] d;
    int i;
    d = m;
    i = 0;
    while ((d & m) != 32'h0 && i < 60) begin
      rd(OFF, RESP_OKAY, d);
      i++;
    end
    chk(d & m, 32'h0);
    @(negedge clock);
    chk(rst_v, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      finish_test();
    end
  end

  initial begin
    rstn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    wstrb = 4'h0;
    ack_delay = 8'h0A;
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    @(negedge clock);
    chk(rst_v, 32'h0);
    rd(OFF, RESP_OKAY, v);
    chk(v, RST_CTRL_RESET);
    for (int b = 0; b < 32; b++) begin
      if (RST_IMPL_MASK[b]) begin
        wr(OFF, 32'h1 << b, 4'hF, RESP_OKAY);
        @(negedge clock);
        chk(rst_v, (b >= 30) ? (UM | (32'h1 << b)) : (32'h1 << b));
        rd(OFF, RESP_OKAY, v);
        chk(v, 32'h1 << b);
        wait_clear(32'h1 << b);
      end
    end
    // A prompt acknowledge must not cut the pulse below its minimum.
    ack_delay <= 8'h00;
    wr(OFF, 32'h0000_0001, 4'hF, RESP_OKAY);
    @(negedge clock);
    chk(rst_v, 32'h0000_0001);
    rd(OFF, RESP_OKAY, v);
    chk(v, 32'h0000_0001);
    wait_clear(32'h0000_0001);
    // Slow units keep the bits busy while zeros and gated lanes are written.
    ack_delay <= 8'h28;
    wr(OFF, 32'h1000_2001, 4'hF, RESP_OKAY);
    wr(OFF, 32'h0, 4'hF, RESP_OKAY);
    wr(OFF, 32'h0000_0002, 4'hE, RESP_OKAY);
    rd(OFF, RESP_OKAY, v);
    chk(v, 32'h1000_2001);
    repeat (20) @(posedge clock);
    @(negedge clock);
    chk(rst_v, 32'h1000_2001);
    wait_clear(32'h1000_2001);
    wr(OFF, 32'h0A00_0600, 4'hF, RESP_OKAY);
    rd(OFF, RESP_OKAY, v);
    chk(v, 32'h0);
    wr(12'h008, 32'hFFFF_FFFF, 4'hF, RESP_DECERR);
    rd(12'h008, RESP_DECERR, v);
    chk(v, 32'h0);
    // Resets written in one word start together.
    wr(OFF, 32'h05A4_0000, 4'hF, RESP_OKAY);
    @(negedge clock);
    chk(rst_v, 32'h05A4_0000);
    wait_clear(32'h05A4_0000);
    // A reset in mid-run clears a pending request at once.
    wr(OFF, 32'h0000_0020, 4'hF, RESP_OKAY);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    @(negedge clock);
    chk(rst_v, 32'h0);
    rd(OFF, RESP_OKAY, v);
    chk(v, RST_CTRL_RESET);
    rd(OFF, RESP_OKAY, v);
    chk(v, 32'h0);
    finish_test();
  end
endmodule
